// file: src/ssd_pkg.sv
// shared types and constants of the state-setup command decoder
package ssd_pkg;

  // header field codes
  localparam logic [2:0] CMD_TYPE_GFX = 3'h3;
  localparam logic [1:0] SUBTYPE_COMMON = 2'h0;
  localparam logic [1:0] SUBTYPE_SINGLE_DW = 2'h1;
  localparam logic [2:0] OPCODE_PIPELINED = 3'h0;
  localparam logic [2:0] OPCODE_NONPIPELINED = 3'h1;
  localparam logic [7:0] SUBOP_BASE_ADDR = 8'h01;
  localparam logic [7:0] SUBOP_SYS_ROUTINE = 8'h02;
  localparam logic [7:0] SUBOP_PREFETCH = 8'h03;
  localparam logic [7:0] SUBOP_INVALIDATE = 8'h0f;
  localparam logic [7:0] LEN_BASE_ADDR = 8'h04;
  localparam logic [7:0] LEN_SYS_ROUTINE = 8'h00;
  localparam logic [7:0] LEN_PREFETCH = 8'h00;

  // dword index of each base-address body dword, and of the last one per command
  localparam logic [2:0] DW_GENERAL_BASE = 3'h1;
  localparam logic [2:0] DW_SURFACE_BASE = 3'h2;
  localparam logic [2:0] DW_INDIRECT_BASE = 3'h3;
  localparam logic [2:0] DW_GENERAL_BOUND = 3'h4;
  localparam logic [2:0] DW_INDIRECT_BOUND = 3'h5;
  localparam logic [2:0] DW_FIRST_BODY = 3'h1;
  localparam logic [2:0] DW_LAST_SHORT = 3'h1;

  localparam logic MODIFY_ENABLE = 1'h1;
  localparam logic [19:0] BOUND_OFF = 20'h00000;
  localparam logic [19:0] BOUND_ALL_ONES = 20'hfffff;

  // invalidate select bits in the single-dword command
  localparam int INV_MEDIA_BIT = 0;
  localparam int INV_CONST_BIT = 1;
  localparam int INV_PIPELINED_BIT = 2;

  // pointer classes tracked for validity
  localparam int PTR_PIPELINED = 0;
  localparam int PTR_COLOR_CALC = 1;
  localparam int PTR_CONST = 2;
  localparam int PTR_MEDIA = 3;
  localparam int PTR_CLASSES = 4;

  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_GENERAL_BASE = 8'h08;
  localparam logic [7:0] REG_SURFACE_BASE = 8'h0c;
  localparam logic [7:0] REG_INDIRECT_BASE = 8'h10;
  localparam logic [7:0] REG_GENERAL_BOUND = 8'h14;
  localparam logic [7:0] REG_INDIRECT_BOUND = 8'h18;
  localparam logic [7:0] REG_SYS_ROUTINE = 8'h1c;
  localparam logic [7:0] REG_PTR_VALID = 8'h20;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_HDR_ERR_BIT = 1;
  localparam int STATUS_DRAIN_BIT = 2;
  localparam logic CTRL_ENABLE_RESET = 1'h1;

  typedef enum logic [1:0] {CHK_GENERAL_RD, CHK_GENERAL_WR, CHK_INDIRECT, CHK_INDIRECT_NODATA} ssd_chk_kind_t;
  typedef enum {ST_HEADER, ST_BODY, ST_DRAIN, ST_PREFETCH} ssd_state_t;
  typedef enum {CMD_BASE, CMD_SYS_ROUTINE, CMD_PREFETCH} ssd_cmd_t;

  typedef struct packed {
    logic [2:0] cmdType;
    logic [1:0] subType;
    logic [2:0] opcode;
    logic [7:0] subOpcode;
    logic [7:0] reserved;
    logic [7:0] dwLength;
  } ssd_header_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [10:0] reserved;
    logic modify;
  } ssd_base_dw_t;

  typedef struct packed {
    logic [25:0] line;
    logic [2:0] reserved;
    logic [2:0] count;
  } ssd_prefetch_dw_t;

  typedef struct packed {
    logic [27:0] offset;
    logic [3:0] reserved;
  } ssd_sys_routine_dw_t;

  typedef struct packed {
    logic [19:0] generalBase;
    logic [19:0] surfaceBase;
    logic [19:0] indirectBase;
    logic [19:0] generalBound;
    logic [19:0] indirectBound;
    logic [31:0] sysRoutineAddr;
  } ssd_bases_t;

  typedef struct packed {
    logic valid;
    ssd_chk_kind_t kind;
    logic [31:0] addr;
  } ssd_chk_req_t;

  typedef struct packed {
    ssd_state_t fsm;
    ssd_cmd_t cmd;
    logic [2:0] idx;
    logic [2:0] last;
    ssd_bases_t bases;
    logic [27:0] sysRoutineOff;
    logic [25:0] pfLine;
    logic [2:0] pfLeft;
    logic [PTR_CLASSES-1:0] ptrValid;
    logic enable;
    logic hdrErr;
    logic [31:0] rdData;
    logic chkDone;
    logic chkZero;
  } ssd_state_vec_t;

endpackage : ssd_pkg

// file: src/ssd_state_decoder.sv
// state-setup command decoder: base addresses, pointer invalidate, prefetch, system routine pointer
`timescale 1ns/1ns
module ssd_state_decoder
  import ssd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic cmdValid,
  input wire logic [31:0] cmdDword,
  output logic cmdReady,
  output logic drainReq,
  input wire logic pipeIdle,
  output logic pfReqValid,
  output logic [31:0] pfReqAddr,
  input wire logic pfReqReady,
  input wire logic [PTR_CLASSES-1:0] ptrLoad,
  output logic [PTR_CLASSES-1:0] ptrValid,
  output ssd_bases_t bases,
  input ssd_chk_req_t chkReq,
  output logic chkDone,
  output logic chkZero,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [31:0] regRdData
);

  ssd_state_vec_t s_q;
  ssd_state_vec_t s_d;
  ssd_header_t hdr;
  ssd_base_dw_t baseDw;
  ssd_prefetch_dw_t pfDw;
  ssd_sys_routine_dw_t sipDw;
  logic take;
  logic isBaseCmd;
  logic isSipCmd;
  logic isPrefetchCmd;
  logic isInvalidateCmd;

  assign hdr = ssd_header_t'(cmdDword);
  assign baseDw = ssd_base_dw_t'(cmdDword);
  assign pfDw = ssd_prefetch_dw_t'(cmdDword);
  assign sipDw = ssd_sys_routine_dw_t'(cmdDword);

  // commands stall entirely while draining or prefetching
  assign cmdReady = s_q.enable && (s_q.fsm == ST_HEADER || s_q.fsm == ST_BODY);
  assign take = cmdValid && cmdReady;
  assign drainReq = (s_q.fsm == ST_DRAIN);
  assign pfReqValid = (s_q.fsm == ST_PREFETCH);
  assign pfReqAddr = {s_q.pfLine, 6'h00};
  assign ptrValid = s_q.ptrValid;
  assign bases = s_q.bases;
  assign chkDone = s_q.chkDone;
  assign chkZero = s_q.chkZero;
  assign regRdData = s_q.rdData;

  // base, routine and prefetch matches include the length field, so a wrong length there is treated as unknown; invalidate ignores it
  assign isBaseCmd = hdr.cmdType == CMD_TYPE_GFX && hdr.subType == SUBTYPE_COMMON
    && hdr.opcode == OPCODE_NONPIPELINED && hdr.subOpcode == SUBOP_BASE_ADDR && hdr.dwLength == LEN_BASE_ADDR;
  assign isSipCmd = hdr.cmdType == CMD_TYPE_GFX && hdr.subType == SUBTYPE_COMMON
    && hdr.opcode == OPCODE_NONPIPELINED && hdr.subOpcode == SUBOP_SYS_ROUTINE && hdr.dwLength == LEN_SYS_ROUTINE;
  assign isPrefetchCmd = hdr.cmdType == CMD_TYPE_GFX && hdr.subType == SUBTYPE_COMMON
    && hdr.opcode == OPCODE_PIPELINED && hdr.subOpcode == SUBOP_PREFETCH && hdr.dwLength == LEN_PREFETCH;
  assign isInvalidateCmd = hdr.cmdType == CMD_TYPE_GFX && hdr.subType == SUBTYPE_SINGLE_DW
    && hdr.opcode == OPCODE_PIPELINED && hdr.subOpcode == SUBOP_INVALIDATE;

  always_comb
  begin
    s_d = s_q;
    s_d.rdData = 32'h00000000;
    s_d.chkDone = 1'b0;
    s_d.chkZero = 1'b0;

    // software writes first so a same-cycle hardware set wins over the clear
    if (regWrStrobe)
    begin
      if (regAddr == REG_CTRL)
        s_d.enable = regWrData[CTRL_ENABLE_BIT];
      if (regAddr == REG_STATUS && regWrData[STATUS_HDR_ERR_BIT])
        s_d.hdrErr = 1'b0;
    end

    unique case (s_q.fsm)
      ST_HEADER:
      begin
        if (take)
        begin
          s_d.idx = DW_FIRST_BODY;
          s_d.last = DW_LAST_SHORT;
          if (isBaseCmd)
          begin
            s_d.cmd = CMD_BASE;
            s_d.last = DW_INDIRECT_BOUND;
            s_d.fsm = ST_BODY;
          end
          else if (isSipCmd)
          begin
            s_d.cmd = CMD_SYS_ROUTINE;
            s_d.fsm = ST_BODY;
          end
          else if (isPrefetchCmd)
          begin
            s_d.cmd = CMD_PREFETCH;
            s_d.fsm = ST_BODY;
          end
          else if (isInvalidateCmd)
          begin
            // only selected classes drop; others keep their state
            if (cmdDword[INV_PIPELINED_BIT])
            begin
              s_d.ptrValid[PTR_PIPELINED] = 1'b0;
              s_d.ptrValid[PTR_COLOR_CALC] = 1'b0;
            end
            if (cmdDword[INV_CONST_BIT])
              s_d.ptrValid[PTR_CONST] = 1'b0;
            if (cmdDword[INV_MEDIA_BIT])
              s_d.ptrValid[PTR_MEDIA] = 1'b0;
          end
          else
            s_d.hdrErr = 1'b1;
        end
      end
      ST_BODY:
      begin
        if (take)
        begin
          unique case (s_q.cmd)
            CMD_BASE:
            begin
              // each dword is gated by its own modify flag; 0 keeps the old value
              if (baseDw.modify == MODIFY_ENABLE)
              begin
                unique case (s_q.idx)
                  DW_GENERAL_BASE: s_d.bases.generalBase = baseDw.addr;
                  DW_SURFACE_BASE: s_d.bases.surfaceBase = baseDw.addr;
                  DW_INDIRECT_BASE: s_d.bases.indirectBase = baseDw.addr;
                  DW_GENERAL_BOUND: s_d.bases.generalBound = baseDw.addr;
                  DW_INDIRECT_BOUND: s_d.bases.indirectBound = baseDw.addr;
                  default: s_d.hdrErr = s_q.hdrErr;
                endcase
              end
            end
            CMD_SYS_ROUTINE: s_d.sysRoutineOff = sipDw.offset;
            CMD_PREFETCH:
            begin
              s_d.pfLine = pfDw.line;
              s_d.pfLeft = pfDw.count;
            end
          endcase
          if (s_q.idx == s_q.last)
          begin
            if (s_q.cmd == CMD_BASE)
              s_d.fsm = ST_DRAIN;
            else if (s_q.cmd == CMD_PREFETCH)
              s_d.fsm = ST_PREFETCH;
            else
              s_d.fsm = ST_HEADER;
          end
          else
            s_d.idx = s_q.idx + 3'h1;
        end
      end
      ST_DRAIN:
      begin
        if (pipeIdle)
          s_d.fsm = ST_HEADER;
      end
      ST_PREFETCH:
      begin
        if (pfReqReady)
        begin
          if (s_q.pfLeft == 3'h0)
            s_d.fsm = ST_HEADER;
          else
          begin
            s_d.pfLeft = s_q.pfLeft - 3'h1;
            s_d.pfLine = s_q.pfLine + 26'h0000001;
          end
        end
      end
    endcase

    // a pointer load arriving with an invalidate leaves the class valid
    s_d.ptrValid = s_d.ptrValid | ptrLoad;

    // one pointer per context; follows base changes so every thread sees the same start
    s_d.bases.sysRoutineAddr = {s_d.bases.generalBase, 12'h000} + {s_d.sysRoutineOff, 4'h0};

    // range checks; bases are the ones that later fetches offset from
    if (chkReq.valid)
    begin
      s_d.chkDone = 1'b1;
      unique case (chkReq.kind)
        CHK_GENERAL_RD, CHK_GENERAL_WR:
          s_d.chkZero = s_q.bases.generalBound != BOUND_OFF
            && chkReq.addr[31:12] >= s_q.bases.generalBound;
        CHK_INDIRECT:
          s_d.chkZero = s_q.bases.indirectBound != BOUND_OFF
            && s_q.bases.indirectBound != BOUND_ALL_ONES
            && chkReq.addr[31:12] >= s_q.bases.indirectBound;
        CHK_INDIRECT_NODATA: s_d.chkZero = 1'b0;
      endcase
    end

    if (regRdStrobe)
    begin
      unique case (regAddr)
        REG_CTRL: s_d.rdData[CTRL_ENABLE_BIT] = s_q.enable;
        REG_STATUS:
        begin
          s_d.rdData[STATUS_BUSY_BIT] = s_q.fsm != ST_HEADER;
          s_d.rdData[STATUS_HDR_ERR_BIT] = s_q.hdrErr;
          s_d.rdData[STATUS_DRAIN_BIT] = s_q.fsm == ST_DRAIN;
        end
        REG_GENERAL_BASE: s_d.rdData = {s_q.bases.generalBase, 12'h000};
        REG_SURFACE_BASE: s_d.rdData = {s_q.bases.surfaceBase, 12'h000};
        REG_INDIRECT_BASE: s_d.rdData = {s_q.bases.indirectBase, 12'h000};
        REG_GENERAL_BOUND: s_d.rdData = {s_q.bases.generalBound, 12'h000};
        REG_INDIRECT_BOUND: s_d.rdData = {s_q.bases.indirectBound, 12'h000};
        REG_SYS_ROUTINE: s_d.rdData = s_q.bases.sysRoutineAddr;
        REG_PTR_VALID: s_d.rdData[PTR_CLASSES-1:0] = s_q.ptrValid;
        default: s_d.rdData = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.fsm <= ST_HEADER;
      s_q.cmd <= CMD_BASE;
      s_q.enable <= CTRL_ENABLE_RESET;
    end
    else if (clkEn)
      s_q <= s_d;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !clkEn);

  logic baseBody;
  assign baseBody = take && s_q.fsm == ST_BODY && s_q.cmd == CMD_BASE;

  a_general_base_load: assert property (baseBody && s_q.idx == DW_GENERAL_BASE && cmdDword[0]
    |=> bases.generalBase == $past(cmdDword[31:12]))
    else $error("general base not loaded");
  a_base_modify_keep: assert property (baseBody && !cmdDword[0] |=> $stable(bases.generalBase)
    && $stable(bases.surfaceBase) && $stable(bases.indirectBase))
    else $error("base changed without modify flag");
  a_surface_base_load: assert property (baseBody && s_q.idx == DW_SURFACE_BASE && cmdDword[0]
    |=> bases.surfaceBase == $past(cmdDword[31:12]) && $stable(bases.generalBase))
    else $error("surface base not loaded");
  a_bound_load: assert property (baseBody && s_q.idx == DW_INDIRECT_BOUND && cmdDword[0]
    |=> bases.indirectBound == $past(cmdDword[31:12]) && drainReq)
    else $error("indirect bound not loaded or no drain");
  a_drain_stall: assert property (drainReq && !pipeIdle |=> drainReq && !cmdReady)
    else $error("commands passed an unfinished drain");
  a_general_bound_zero: assert property (chkReq.valid && chkReq.kind == CHK_GENERAL_RD
    && bases.generalBound != 20'h00000 && chkReq.addr[31:12] >= bases.generalBound |=> chkDone && chkZero)
    else $error("general read above bound not zeroed");
  a_indirect_range: assert property (chkReq.valid && chkReq.kind == CHK_INDIRECT
    && (bases.indirectBound == 20'h00000 || bases.indirectBound == 20'hfffff) |=> !chkZero)
    else $error("disabled indirect check zeroed data");
  a_indirect_above: assert property (chkReq.valid && chkReq.kind == CHK_INDIRECT
    && bases.indirectBound != 20'h00000 && bases.indirectBound != 20'hfffff
    && chkReq.addr[31:12] >= bases.indirectBound |=> chkZero)
    else $error("indirect fetch above bound not zeroed");
  a_nodata_pass: assert property (chkReq.valid && chkReq.kind == CHK_INDIRECT_NODATA |=> chkDone && !chkZero)
    else $error("bound applied to work without indirect data");
  a_media_invalidate: assert property (take && s_q.fsm == ST_HEADER && isInvalidateCmd && cmdDword[0]
    && !ptrLoad[3] |=> !ptrValid[3])
    else $error("media pointers not invalidated");
  a_const_kept: assert property (take && s_q.fsm == ST_HEADER && isInvalidateCmd && !cmdDword[1]
    |=> ptrValid[2] == $past(ptrValid[2] || ptrLoad[2]))
    else $error("constant pointer touched without select");
  a_prefetch_align: assert property (pfReqValid |-> pfReqAddr[5:0] == 6'h00)
    else $error("prefetch line not 64-byte aligned");
  a_prefetch_count: assert property (take && s_q.fsm == ST_BODY && s_q.cmd == CMD_PREFETCH
    && cmdDword[2:0] == 3'h0 ##1 pfReqReady |=> !pfReqValid)
    else $error("single-line prefetch issued more than one line");
  a_sip_addr: assert property (take && s_q.fsm == ST_BODY && s_q.cmd == CMD_SYS_ROUTINE
    |=> bases.sysRoutineAddr == {bases.generalBase, 12'h000} + {$past(cmdDword[31:4]), 4'h0})
    else $error("system routine address wrong");
  a_bad_header: assert property (take && s_q.fsm == ST_HEADER && !isBaseCmd && !isSipCmd
    && !isPrefetchCmd && !isInvalidateCmd |=> s_q.hdrErr && s_q.fsm == ST_HEADER)
    else $error("unknown header not flagged");

  c_base_drain: cover property (drainReq ##1 pipeIdle ##1 cmdReady);
  c_prefetch_eight: cover property (pfReqValid && s_q.pfLeft == 3'h7);
  c_invalidate_all: cover property (take && isInvalidateCmd && cmdDword[2:0] == 3'h7);

endmodule : ssd_state_decoder

// file: sim/ssd_cmd_source.sv
// command buffer source: offers queued dwords with random gaps
`timescale 1ns/1ns
module ssd_cmd_source
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cmdReady,
  output logic cmdValid,
  output logic [31:0] cmdDword
);
  logic [31:0] pending[$];
  initial
  begin
    cmdValid = 1'b0;
    cmdDword = 32'h0;
  end
  task automatic push(input logic [31:0] dw);
    pending.push_back(dw);
  endtask : push
  // a dword is held until taken; idle data keeps changing so stale values never look valid
  always @(posedge clk)
  begin
    if (rst)
      cmdValid <= 1'b0;
    else if (!cmdValid || cmdReady)
    begin
      if (pending.size() > 0 && $urandom_range(3) != 0)
      begin
        cmdValid <= 1'b1;
        cmdDword <= pending.pop_front();
      end
      else
      begin
        cmdValid <= 1'b0;
        cmdDword <= ~cmdDword;
      end
    end
  end
endmodule : ssd_cmd_source

// file: sim/ssd_state_decoder_tb.sv
// self-checking bench of the state-setup command decoder
`timescale 1ns/1ns
module ssd_state_decoder_tb;
  import ssd_pkg::*;
  localparam logic [7:0] REG_LIST [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h44};
  logic clk, rst, cmdValid, cmdReady, drainReq, pipeIdle, pfReqValid, pfReqReady, chkDone, chkZero;
  logic regWrStrobe, regRdStrobe, holdBusy;
  logic [31:0] cmdDword, pfReqAddr, regWrData, regRdData;
  logic [7:0] regAddr;
  logic [PTR_CLASSES-1:0] ptrLoad, ptrValid;
  ssd_bases_t bases;
  ssd_chk_req_t chkReq;
  logic [19:0] expB[1:5];
  logic [31:0] pfSeen[$];
  int bad_count, compares, cycles;

  ssd_state_decoder uut (.clk(clk), .rst(rst), .clkEn(1'b1), .cmdValid(cmdValid), .cmdDword(cmdDword),
    .cmdReady(cmdReady), .drainReq(drainReq), .pipeIdle(pipeIdle), .pfReqValid(pfReqValid),
    .pfReqAddr(pfReqAddr), .pfReqReady(pfReqReady), .ptrLoad(ptrLoad), .ptrValid(ptrValid), .bases(bases),
    .chkReq(chkReq), .chkDone(chkDone), .chkZero(chkZero), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData));
  ssd_cmd_source src (.clk(clk), .rst(rst), .cmdReady(cmdReady), .cmdValid(cmdValid), .cmdDword(cmdDword));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // far-side stalls are random; drain can be held off on purpose
  always @(posedge clk)
  begin
    pfReqReady <= 1'($urandom_range(1));
    pipeIdle <= !holdBusy && 1'($urandom_range(1));
    if (pfReqValid && pfReqReady)
      pfSeen.push_back(pfReqAddr);
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrStrobe <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRdStrobe <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1;
    d = regRdData;
  endtask : reg_rd

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((src.pending.size() != 0 || cmdValid !== 1'b0 || cmdReady !== 1'b1) && n < 2000);
    // a stream that never drains is a hang, counted as a mismatch
    if (n >= 2000)
      bad_count++;
    repeat (2) @(posedge clk);
    #1;
  endtask : wait_idle

  task automatic chk(input ssd_chk_kind_t k, input logic [31:0] a);
    @(posedge clk);
    chkReq <= '{1'b1, k, a};
    @(posedge clk);
    chkReq <= '{1'b0, k, ~a};
    #1;
    cmp("chkDone", 32'h1, {31'h0, chkDone});
    cmp("chkZero", {31'h0, exp_zero(k, a)}, {31'h0, chkZero});
  endtask : chk

  function automatic logic [31:0] hdr(input logic [1:0] st, input logic [2:0] op, input logic [7:0] so,
    input logic [7:0] len);
    return {CMD_TYPE_GFX, st, op, so, 8'h00, len};
  endfunction : hdr

  function automatic logic exp_zero(input ssd_chk_kind_t k, input logic [31:0] a);
    if (k == CHK_INDIRECT_NODATA)
      return 1'b0;
    if (k == CHK_INDIRECT)
      return expB[5] != BOUND_OFF && expB[5] != BOUND_ALL_ONES && a[31:12] >= expB[5];
    return expB[4] != BOUND_OFF && a[31:12] >= expB[4];
  endfunction : exp_zero

  function automatic logic [PTR_CLASSES-1:0] exp_ptr(input logic [2:0] b);
    logic [PTR_CLASSES-1:0] v;
    v = '1;
    if (b[INV_MEDIA_BIT])
      v[PTR_MEDIA] = 1'b0;
    if (b[INV_CONST_BIT])
      v[PTR_CONST] = 1'b0;
    if (b[INV_PIPELINED_BIT])
      v[PTR_PIPELINED] = 1'b0;
    if (b[INV_PIPELINED_BIT])
      v[PTR_COLOR_CALC] = 1'b0;
    return v;
  endfunction : exp_ptr

  function automatic logic [19:0] got_base(input int j);
    case (j)
      1: return bases.generalBase;
      2: return bases.surfaceBase;
      3: return bases.indirectBase;
      4: return bases.generalBound;
      default: return bases.indirectBound;
    endcase
  endfunction : got_base

  initial
  begin
    logic [31:0] d, line;
    ssd_chk_kind_t k;
    int n;
    rst = 1'b1;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    ptrLoad = '0;
    chkReq = '0;
    holdBusy = 1'b0;
    pipeIdle = 1'b0;
    pfReqReady = 1'b0;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    foreach (expB[j])
      expB[j] = 20'h0;
    void'($urandom(32'h773f));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_wr(8'h44, 32'hffffffff);
    for (int i = 0; i < 10; i++)
    begin
      reg_rd(REG_LIST[i], d);
      cmp("register reset", (REG_LIST[i] == REG_CTRL) ? 32'h1 : 32'h0, d);
    end
    for (int it = 0; it < 4; it++)
    begin
      logic [31:0] dw[1:5];
      for (int j = 1; j <= 5; j++)
        dw[j] = {20'($urandom), 11'h0, (it == 0) ? 1'b1 : 1'($urandom_range(1))};
      if (it == 0)
        dw[5][31:12] = dw[3][31:12] + 20'h100;
      if (it == 1)
        dw[5] = 32'h1;
      if (it == 2)
        dw[5] = {BOUND_ALL_ONES, 12'h1};
      holdBusy <= 1'b1;
      src.push(hdr(SUBTYPE_COMMON, OPCODE_NONPIPELINED, SUBOP_BASE_ADDR, LEN_BASE_ADDR));
      for (int j = 1; j <= 5; j++)
      begin
        src.push(dw[j]);
        if (dw[j][0] == MODIFY_ENABLE)
          expB[j] = dw[j][31:12];
      end
      n = 0;
      while (drainReq !== 1'b1 && n < 200)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 200)
        bad_count++;
      repeat (3)
      begin
        @(posedge clk);
        #1;
        cmp("intake during drain", 32'h0, {31'h0, cmdReady});
      end
      holdBusy <= 1'b0;
      wait_idle();
      for (int j = 1; j <= 5; j++)
        cmp("base field", {12'h0, expB[j]}, {12'h0, got_base(j)});
      reg_rd(REG_INDIRECT_BOUND, d);
      cmp("bound register", {expB[5], 12'h0}, d);
      for (int i = 0; i < 8; i++)
      begin
        k = ssd_chk_kind_t'($urandom_range(3));
        line[31:12] = (k == CHK_GENERAL_RD || k == CHK_GENERAL_WR) ? expB[4] : expB[5];
        chk(k, {line[31:12] + 20'($urandom_range(3)) - 20'h2, 12'($urandom)});
      end
    end
    d = {28'($urandom), 4'h0};
    src.push(hdr(SUBTYPE_COMMON, OPCODE_NONPIPELINED, SUBOP_SYS_ROUTINE, LEN_SYS_ROUTINE));
    src.push(d);
    wait_idle();
    cmp("routine address", {expB[1], 12'h0} + d, bases.sysRoutineAddr);
    for (int c = 0; c < 8; c++)
    begin
      line = {26'($urandom), 6'h0};
      pfSeen.delete();
      src.push(hdr(SUBTYPE_COMMON, OPCODE_PIPELINED, SUBOP_PREFETCH, LEN_PREFETCH));
      src.push(line | 32'(c));
      wait_idle();
      cmp("line count", 32'(c + 1), 32'(pfSeen.size()));
      foreach (pfSeen[i])
        cmp("line address", line + 32'(64 * i), pfSeen[i]);
    end
    for (int b = 0; b < 8; b++)
    begin
      @(posedge clk);
      ptrLoad <= '1;
      @(posedge clk);
      ptrLoad <= '0;
      src.push(hdr(SUBTYPE_SINGLE_DW, OPCODE_PIPELINED, SUBOP_INVALIDATE, 8'(b)));
      wait_idle();
      cmp("pointer flags", {28'h0, exp_ptr(3'(b))}, {28'h0, ptrValid});
    end
    // unknown header is swallowed as one dword and flagged
    src.push(hdr(SUBTYPE_COMMON, OPCODE_PIPELINED, 8'h55, 8'h00));
    wait_idle();
    reg_rd(REG_STATUS, d);
    cmp("header error", 32'h2, d & 32'h2);
    reg_wr(REG_STATUS, 32'h2);
    reg_rd(REG_STATUS, d);
    cmp("header error cleared", 32'h0, d & 32'h2);
    reg_wr(REG_CTRL, 32'h0);
    reg_rd(REG_CTRL, d);
    cmp("enable off", 32'h0, d);
    cmp("intake stalled", 32'h0, {31'h0, cmdReady});
    reg_wr(REG_CTRL, 32'h1);
    give_verdict();
  end
endmodule : ssd_state_decoder_tb
